// [dv/adcc_assertions.sv]
/* Checker bound to adcc_top, fed by its ports only.
   Assumes the time select changes only by a control/status write while no conversion runs. */
`timescale 1ns/100ps
module adcc_assertions
(
    input wire       clk_sys, rst_n, standby, bus_sel, bus_wr, bus_rd,
    input wire [3:0] bus_addr,
    input wire [7:0] bus_wdata, bus_rdata,
    input wire       ext_trigger_pin, conversion_end_irq, core_start, conv_done,
    input wire [2:0] core_channel
);
    wire csr_wr = bus_sel && bus_wr && bus_addr == 4'h8;
    reg  cks_ff;
    // Mirror of the time select, so slot length can be judged
    always @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            cks_ff <= 1'b0;
        else if (csr_wr)
            cks_ff <= bus_wdata[3];
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    slot_len_a: assert property (conv_done |-> (cks_ff ?
        ($past(core_start, 134) || $past(core_start, 128)) :
        ($past(core_start, 266) || $past(core_start, 256)))) else $error("slot length");
    done_gap_a: assert property (core_start |=> !conv_done [*8])
        else $error("early done");
    start_cause_a: assert property (core_start && !conv_done |->
        $past(csr_wr && bus_wdata[5]) || ($past(ext_trigger_pin, 2) && !$past(ext_trigger_pin)))
        else $error("stray start");
    first_ch_a: assert property (core_start && !conv_done &&
        $past(csr_wr && bus_wdata[5]) |->
        core_channel == ($past(bus_wdata[4]) ? {$past(bus_wdata[2]), 2'b00} : $past(bus_wdata[2:0])))
        else $error("first channel");
    scan_step_a: assert property (conv_done && core_start && core_channel[1:0] != 2'b00 |->
        core_channel == $past(core_channel) + 3'd1) else $error("scan order");
    irq_rise_a: assert property ($rose(conversion_end_irq) |-> conv_done || $past(csr_wr))
        else $error("irq rise");
    irq_fall_a: assert property ($fell(conversion_end_irq) |-> $past(csr_wr || standby))
        else $error("irq fall");
    trg_ones_a: assert property (bus_sel && bus_rd && bus_addr == 4'h9 |=> &bus_rdata[6:0])
        else $error("trigger reserved bits");
    cover property (conv_done && core_start);
    cover property ($rose(conversion_end_irq));
    cover property (core_start && !ext_trigger_pin);
endmodule // adcc_assertions
bind adcc_top adcc_assertions u_adcc_assertions (.*);

// [dv/adcc_core_model.sv]
/* Analog core stand-in: one channel-coded result per slot.
   Assumes core_channel is valid while core_start pulses. */
`timescale 1ns/100ps
module adcc_core_model
(
    input  wire       clk_sys,
    input  wire       core_start,
    input  wire [2:0] core_channel,
    output reg  [9:0] core_result_i = 10'h3ff
);
    // Unique per channel, so a misrouted capture shows
    always @(posedge clk_sys)
        if (core_start)
            core_result_i <= {core_channel, 7'h2d};
endmodule // adcc_core_model

// [dv/test_adcc_top.sv]
/* Self-checking bench: register bus tasks, trigger pin, standby.
   Assumes reads answer at the taking edge and are checked half a cycle later. */
`timescale 1ns/100ps
module test_adcc_top;
    reg        clk_sys = 1'b0, rst_n = 1'b0, standby = 1'b0, ext_trigger_pin = 1'b1;
    reg        bus_sel = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    reg  [3:0] bus_addr = 4'h0;
    reg  [7:0] bus_wdata = 8'h00;
    wire [7:0] bus_rdata;
    wire       conversion_end_irq, core_start, conv_done;
    wire [2:0] core_channel;
    wire [9:0] core_result_i;
    int        n_mismatch = 0, total_checks = 0, n_start = 0;
    always #2 clk_sys = ~clk_sys;
    adcc_top u_adcc_top (.*);
    adcc_core_model u_adcc_core_model (.*);
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    // Reads pass the expected value in d
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {bus_sel, bus_wr, bus_rd, bus_addr, bus_wdata} = {1'b1, w, !w, a, d};
        @(negedge clk_sys);
        {bus_sel, bus_wr, bus_rd} = 3'b000;
        if (!w)
            check("rdata", d, bus_rdata);
    endtask
    task automatic wait_done(input int n);
        for (int t = 0; t < 2000 && n > 0; t++)
            @(negedge clk_sys) n -= conv_done;
        check("done", 8'h00, n[7:0]);
    endtask
    // High byte first, so the lower byte comes from the latch
    task automatic chk_res(input logic [2:0] ch);
        logic [9:0] v;
        v = {ch, 7'h2d};
        acc(1'b0, {1'b0, ch[1:0], 1'b0}, v[9:2]);
        acc(1'b0, {1'b0, ch[1:0], 1'b1}, {v[1:0], 6'h00});
    endtask
    task automatic trig;
        @(negedge clk_sys) ext_trigger_pin = 1'b0;
        repeat (3) @(negedge clk_sys);
        ext_trigger_pin = 1'b1;
    endtask
    task tally_and_finish;
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Run needs about 1700 cycles
    initial
    begin
        #40000;
        n_mismatch++;
        tally_and_finish;
    end
    initial
    begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        acc(1'b0, 4'h8, 8'h00);
        acc(1'b0, 4'h9, 8'h7f);
        acc(1'b0, 4'ha, 8'h00);
        trig;
        acc(1'b0, 4'h8, 8'h00);
        acc(1'b1, 4'h8, 8'h61);
        wait_done(1);
        check("irq", 8'h01, {7'h00, conversion_end_irq});
        acc(1'b0, 4'h8, 8'hc1);
        chk_res(3'd1);
        acc(1'b0, 4'h0, 8'h00);
        acc(1'b0, 4'h3, 8'h00);
        acc(1'b1, 4'h8, 8'hc1);
        acc(1'b1, 4'h8, 8'h41);
        acc(1'b0, 4'h8, 8'hc1);
        acc(1'b1, 4'h8, 8'h41);
        acc(1'b0, 4'h8, 8'h41);
        acc(1'b1, 4'h9, 8'hff);
        acc(1'b0, 4'h9, 8'hff);
        acc(1'b1, 4'h8, 8'h0e);
        trig;
        wait_done(1);
        check("irq", 8'h00, {7'h00, conversion_end_irq});
        acc(1'b0, 4'h8, 8'h8e);
        chk_res(3'd6);
        acc(1'b1, 4'h8, 8'h3a);
        wait_done(3);
        acc(1'b0, 4'h8, 8'hba);
        chk_res(3'd2);
        acc(1'b1, 4'h8, 8'h9a);
        repeat (300) @(negedge clk_sys) n_start += (core_start !== 1'b0);
        check("starts", 8'h00, n_start[7:0]);
        acc(1'b0, 4'h8, 8'h9a);
        acc(1'b1, 4'h8, 8'h75);
        wait_done(2);
        check("irq", 8'h01, {7'h00, conversion_end_irq});
        chk_res(3'd5);
        @(negedge clk_sys) standby = 1'b1;
        @(negedge clk_sys) standby = 1'b0;
        acc(1'b0, 4'h8, 8'h00);
        acc(1'b0, 4'h9, 8'h7f);
        acc(1'b0, 4'h2, 8'h00);
        tally_and_finish;
    end
endmodule // test_adcc_top

// [hw/adcc_defs.vh]
/*
 Constants of the converter control and status logic: register offsets,
 field positions, reset values and conversion state counts.
 Assumes one state equals one clk_sys cycle and an 8-bit register bus.
*/
// Notes on behaviour
// RULE_01: End flag, bit 7, sets after a single conversion or a full scan group.
// RULE_02: End flag clears only by zero write after reading it as one.
// RULE_03: Writing one to the end flag does nothing.
// RULE_04: Bit 6 gates the end interrupt; resets to zero.
// RULE_05: Bit 5 starts conversion and reads one while converting.
// RULE_06: Single mode clears the start bit when conversion completes.
// RULE_07: Scan mode converts in rotation until start cleared, reset or standby.
// RULE_08: Bit 4 selects single (0) or scan (1) mode; resets to single.
// RULE_09: Software clears start before changing mode, time select or channel.
// RULE_10: Bit 3 selects 266 states (0) or 134 states (1); resets zero.
// RULE_11: Single mode: bit 2 picks group, bits 1:0 pick input.
// RULE_12: Scan mode converts group inputs from first up to low-bit index.
// RULE_13: Control/status register is zero after reset and standby.
// RULE_14: Trigger enable bit 7 lets a falling trigger edge start conversion.
// RULE_15: Enabled trigger sets the start bit like a software write.
// RULE_16: Trigger control resets to 0x7f; bits 6 to 0 read one.
// RULE_17: Upper result byte read returns it and latches lower byte.
// RULE_18: Lower result byte read returns the temporary latch.
// RULE_19: Software reads upper byte before lower byte.
// RULE_20: Results are 10 bits; only single and scan modes exist.
// RULE_21: Result upper 8 bits in high byte, low 2 at lower byte top.
// RULE_22: Inputs 0/4 to A, 1/5 to B, 2/6 to C, 3/7 to D.
// RULE_23: Later scan conversions take 256 or 128 states.
// RULE_24: Interrupt requested when end flag is one and enable is one.
// RULE_25: Core driven by start, channel index and done strobe, 10-bit result.
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

`define ADCC_OFS_RES_A_HI   4'h0
`define ADCC_OFS_RES_D_LO   4'h7
`define ADCC_OFS_CSR        4'h8
`define ADCC_OFS_TRG        4'h9

`define ADCC_CSR_FLAG       7
`define ADCC_CSR_IE         6
`define ADCC_CSR_START      5
`define ADCC_CSR_SCAN       4
`define ADCC_CSR_CKS        3
`define ADCC_TRG_EN         7

`define ADCC_CSR_RESET      8'h00
`define ADCC_TRG_RESET      8'h7f
`define ADCC_TRG_ONES       7'h7f

`define ADCC_STATES_SLOW    9'd266
`define ADCC_STATES_FAST    9'd134
`define ADCC_STATES_SCAN_S  9'd256
`define ADCC_STATES_SCAN_F  9'd128

`endif

// [hw/adcc_top.v]
/*
 Control and status logic of a 10-bit successive-approximation converter:
 control/status and trigger registers, conversion sequencer, result
 registers with byte-wide read through a temporary latch.
 Assumes an 8-bit register bus synchronous to clk_sys and an analog core
 that drives core_result_i, captured as the sequencer strobes conv_done.
*/
`timescale 1ns/100ps
`include "adcc_defs.vh"

module adcc_top
(
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       standby,
    input  wire       bus_sel,
    input  wire       bus_wr,
    input  wire       bus_rd,
    input  wire [3:0] bus_addr,
    input  wire [7:0] bus_wdata,
    output reg  [7:0] bus_rdata,
    input  wire       ext_trigger_pin,
    output reg        conversion_end_irq,
    output reg        core_start,
    output reg  [2:0] core_channel,
    output reg        conv_done,
    input  wire [9:0] core_result_i
);

    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    reg        rst_meta_ff;
    reg        rst_sync_ff;
    reg        flag_ff;
    reg        ie_ff;
    reg        start_ff;
    reg        scan_ff;
    reg        cks_ff;
    reg  [2:0] chsel_ff;
    reg        trg_en_ff;
    reg        flag_seen_ff;
    reg        trig_prev_ff;
    reg        state_ff;
    reg  [8:0] cnt_ff;
    reg  [1:0] idx_ff;
    reg  [7:0] temp_ff;
    reg  [9:0] res_pick;

    reg        nxt_flag;
    reg        nxt_start;
    reg        nxt_state;
    reg  [8:0] nxt_cnt;
    reg  [1:0] nxt_idx;
    reg        nxt_done;
    reg        nxt_core_start;
    reg  [7:0] nxt_rdata;

    wire       wr_csr   = bus_sel & bus_wr & (bus_addr == `ADCC_OFS_CSR);
    wire       wr_trg   = bus_sel & bus_wr & (bus_addr == `ADCC_OFS_TRG);
    wire       rd_csr   = bus_sel & bus_rd & (bus_addr == `ADCC_OFS_CSR);
    wire       rd_res   = bus_sel & bus_rd & (bus_addr <= `ADCC_OFS_RES_D_LO);
    wire [1:0] res_sel  = bus_addr[2:1];
    wire       trig_hit = trg_en_ff & trig_prev_ff & ~ext_trigger_pin; //RULE_14
    wire [7:0] csr_val  = {flag_ff, ie_ff, start_ff, scan_ff, cks_ff, chsel_ff};
    wire       cnt_end  = (cnt_ff == 9'd1);
    wire       last_ch  = ~scan_ff | (idx_ff == chsel_ff[1:0]);
    // A start written together with new settings uses them at once
    wire       cfg_scan = wr_csr ? bus_wdata[`ADCC_CSR_SCAN] : scan_ff;
    wire       cfg_cks  = wr_csr ? bus_wdata[`ADCC_CSR_CKS] : cks_ff;
    wire [2:0] cfg_ch   = wr_csr ? bus_wdata[2:0] : chsel_ff;
    wire [3:0] res_load = nxt_done ? (4'h1 << idx_ff) : 4'h0; //RULE_22
    wire [9:0] res_word_a; //RULE_20
    wire [9:0] res_word_b;
    wire [9:0] res_word_c;
    wire [9:0] res_word_d;

    // Reset released through two flops; assertion stays asynchronous
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Start bit and sequencer
    always @*
    begin
        nxt_start      = start_ff;
        nxt_flag       = flag_ff;
        nxt_state      = state_ff;
        nxt_cnt        = cnt_ff;
        nxt_idx        = idx_ff;
        nxt_done       = 1'b0;
        nxt_core_start = 1'b0;
        if (wr_csr)
            nxt_start = bus_wdata[`ADCC_CSR_START]; //RULE_05
        if (trig_hit)
            nxt_start = 1'b1; //RULE_15
        if (wr_csr && !bus_wdata[`ADCC_CSR_FLAG] && flag_seen_ff)
            nxt_flag = 1'b0; //RULE_02 RULE_03
        case (state_ff)
            ST_IDLE:
            begin
                if (nxt_start)
                begin
                    nxt_state      = ST_CONV;
                    nxt_idx        = cfg_scan ? 2'b00 : cfg_ch[1:0]; //RULE_11 RULE_12
                    nxt_cnt        = cfg_cks ? `ADCC_STATES_FAST : `ADCC_STATES_SLOW; //RULE_10
                    nxt_core_start = 1'b1;
                end
            end
            ST_CONV:
            begin
                if (!nxt_start)
                    nxt_state = ST_IDLE; //RULE_07
                else if (cnt_end)
                begin
                    nxt_done = 1'b1;
                    if (last_ch)
                        nxt_flag = 1'b1; //RULE_01
                    if (!scan_ff)
                    begin
                        nxt_start = 1'b0; //RULE_06
                        nxt_state = ST_IDLE;
                    end
                    else
                    begin
                        // Scan keeps running; each later slot has the fixed length
                        nxt_idx        = last_ch ? 2'b00 : idx_ff + 2'b01; //RULE_12
                        nxt_cnt        = cks_ff ? `ADCC_STATES_SCAN_F : `ADCC_STATES_SCAN_S; //RULE_23
                        nxt_core_start = 1'b1;
                    end
                end
                else
                    nxt_cnt = cnt_ff - 9'd1;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // Read data; a low byte read returns the latch, not the live word
    always @*
    begin
        nxt_rdata = 8'h00;
        case (res_sel)
            2'd0:    res_pick = res_word_a;
            2'd1:    res_pick = res_word_b;
            2'd2:    res_pick = res_word_c;
            default: res_pick = res_word_d;
        endcase
        if (rd_res)
            nxt_rdata = bus_addr[0] ? temp_ff : res_pick[9:2]; //RULE_18 RULE_21
        else if (bus_addr == `ADCC_OFS_CSR)
            nxt_rdata = csr_val;
        else if (bus_addr == `ADCC_OFS_TRG)
            nxt_rdata = {trg_en_ff, `ADCC_TRG_ONES}; //RULE_16
    end

    // Result words A to D, one per channel index
    adcc_res_word u_adcc_res_word_a
    (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_ff),
        .clear      (standby),
        .load       (res_load[0]),
        .din        (core_result_i),
        .word_ff    (res_word_a)
    );

    adcc_res_word u_adcc_res_word_b
    (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_ff),
        .clear      (standby),
        .load       (res_load[1]),
        .din        (core_result_i),
        .word_ff    (res_word_b)
    );

    adcc_res_word u_adcc_res_word_c
    (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_ff),
        .clear      (standby),
        .load       (res_load[2]),
        .din        (core_result_i),
        .word_ff    (res_word_c)
    );

    adcc_res_word u_adcc_res_word_d
    (
        .clk_sys    (clk_sys),
        .rst_sync_n (rst_sync_ff),
        .clear      (standby),
        .load       (res_load[3]),
        .din        (core_result_i),
        .word_ff    (res_word_d)
    );

    // Registers; standby clears like reset
    always @(posedge clk_sys or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            flag_ff            <= 1'b0;
            ie_ff              <= 1'b0;
            start_ff           <= 1'b0;
            scan_ff            <= 1'b0;
            cks_ff             <= 1'b0;
            chsel_ff           <= 3'h0;
            trg_en_ff          <= 1'b0;
            flag_seen_ff       <= 1'b0;
            trig_prev_ff       <= 1'b1;
            state_ff           <= ST_IDLE;
            cnt_ff             <= 9'h000;
            idx_ff             <= 2'h0;
            temp_ff            <= 8'h00;
            bus_rdata          <= 8'h00;
            conversion_end_irq <= 1'b0;
            core_start         <= 1'b0;
            core_channel       <= 3'h0;
            conv_done          <= 1'b0;
        end
        else if (standby)
        begin
            flag_ff            <= 1'b0; //RULE_13
            ie_ff              <= 1'b0;
            start_ff           <= 1'b0; //RULE_07
            scan_ff            <= 1'b0;
            cks_ff             <= 1'b0;
            chsel_ff           <= 3'h0;
            trg_en_ff          <= 1'b0; //RULE_16
            flag_seen_ff       <= 1'b0;
            trig_prev_ff       <= 1'b1;
            state_ff           <= ST_IDLE;
            cnt_ff             <= 9'h000;
            idx_ff             <= 2'h0;
            temp_ff            <= 8'h00;
            bus_rdata          <= 8'h00;
            conversion_end_irq <= 1'b0;
            core_start         <= 1'b0;
            core_channel       <= 3'h0;
            conv_done          <= 1'b0;
        end
        else
        begin
            flag_ff      <= nxt_flag;
            start_ff     <= nxt_start;
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            idx_ff       <= nxt_idx;
            trig_prev_ff <= ext_trigger_pin;
            if (wr_csr)
            begin
                ie_ff    <= bus_wdata[`ADCC_CSR_IE]; //RULE_04
                scan_ff  <= bus_wdata[`ADCC_CSR_SCAN]; //RULE_08
                cks_ff   <= bus_wdata[`ADCC_CSR_CKS];
                chsel_ff <= bus_wdata[2:0];
            end
            if (wr_trg)
                trg_en_ff <= bus_wdata[`ADCC_TRG_EN];
            // Read-first arming; a new set re-arms only after another read
            if (rd_csr && flag_ff)
                flag_seen_ff <= 1'b1;
            else if (wr_csr || !nxt_flag)
                flag_seen_ff <= 1'b0;
            conversion_end_irq <= nxt_flag & (wr_csr ? bus_wdata[`ADCC_CSR_IE] : ie_ff); //RULE_24
            core_start   <= nxt_core_start; //RULE_25
            core_channel <= {cfg_ch[2], nxt_idx}; //RULE_11
            conv_done    <= nxt_done;
            if (rd_res && !bus_addr[0])
                temp_ff <= {res_pick[1:0], 6'h00}; //RULE_17 RULE_21
            if (bus_sel && bus_rd)
                bus_rdata <= nxt_rdata;
        end
    end

endmodule // adcc_top

// One result word; cleared by reset and standby, loaded at conversion end
module adcc_res_word
#(
    parameter WIDTH = 10
)
(
    input  wire             clk_sys,
    input  wire             rst_sync_n,
    input  wire             clear,
    input  wire             load,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] word_ff
);

    always @(posedge clk_sys or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            word_ff <= {WIDTH{1'b0}};
        else if (clear)
            word_ff <= {WIDTH{1'b0}};
        else if (load)
            word_ff <= din; //RULE_20 RULE_25
    end

endmodule // adcc_res_word
